// ---- hdl/nvmpc_pkg.sv ----
// nvmpc_pkg: opcodes, field positions, defaults and states of the
// protection and configuration register bank.
// assumes a 22-bit byte address for the array and byte-wide registers.
package nvmpc_pkg;

  // link opcodes
  localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_DUAL_EN    = 8'h37;
  localparam logic [7:0] CMD_QUAD_EN    = 8'h38;
  localparam logic [7:0] CMD_SINGLE_EN  = 8'hFF;
  localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
  localparam logic [7:0] CMD_RD_CFG1    = 8'h35;
  localparam logic [7:0] CMD_RD_CFG2    = 8'h3F;
  localparam logic [7:0] CMD_RD_CFG3    = 8'h44;
  localparam logic [7:0] CMD_RD_CFG4    = 8'h45;
  localparam logic [7:0] CMD_RD_CFGX    = 8'h46;
  localparam logic [7:0] CMD_RD_IDENT   = 8'h9F;
  localparam logic [7:0] CMD_RD_UNIQ    = 8'h4C;
  localparam logic [7:0] CMD_RD_SERIAL  = 8'hC3;
  localparam logic [7:0] CMD_RD_AUGPROT = 8'h14;
  localparam logic [7:0] CMD_WR_STATUS  = 8'h01;
  localparam logic [7:0] CMD_WR_CFGX    = 8'h87;
  localparam logic [7:0] CMD_WR_SERIAL  = 8'hC2;
  localparam logic [7:0] CMD_WR_AUGPROT = 8'h1A;

  // field positions
  localparam int STAT_HPE_BIT   = 7;
  localparam int STAT_SNP_BIT   = 6;
  localparam int STAT_TBS_BIT   = 5;
  localparam int LOCK_ARRAY_BIT = 2;
  localparam int LOCK_AUG_BIT   = 0;
  localparam int IFC_QUAD_BIT   = 6;
  localparam int IFC_DUAL_BIT   = 4;
  localparam int WRAP_EN_BIT    = 4;
  localparam logic [7:0] IFC_FLAG_MASK = 8'h50;

  // write-enable policy codes and read kinds
  localparam logic [1:0] WEP_SRAM  = 2'h1;
  localparam logic [1:0] WEP_B2B   = 2'h2;
  localparam logic [1:0] RK_BASIC  = 2'h0;
  localparam logic [1:0] RK_ANYREG = 2'h2;

  // latencies, wrap and block-protect codes
  localparam logic [3:0]  LAT_NONE   = 4'h0;
  localparam logic [3:0]  LAT_ANY_1  = 4'h8;
  localparam logic [3:0]  LAT_ANY_2  = 4'h4;
  localparam logic [3:0]  LAT_ANY_4  = 4'h2;
  localparam logic [2:0]  WRAP_RSVD  = 3'h7;
  localparam logic [21:0] WRAP_BASE  = 22'h000010;
  localparam logic [2:0]  BPF_NONE   = 3'h0;
  localparam logic [2:0]  BPF_ALL    = 3'h7;

  // factory defaults of the nonvolatile bytes
  localparam logic [5:0]  STAT_NV_DFLT = 6'h00;
  localparam logic [7:0]  CFG_DFLT     = 8'h00;
  localparam logic [7:0]  AUGP_DFLT    = 8'h00;
  localparam logic [63:0] SERIAL_DFLT  = 64'h0;

  // identity; maker code and unique value are arbitrary
  localparam logic [7:0]  MAKER_CODE   = 8'h5A;
  localparam logic [23:0] IDENT_CONFIG = 24'h010601;
  localparam logic [63:0] UNIQ_VALUE   = 64'h13579BDF2468ACE0;

  typedef enum logic [1:0] {
    PH_CMD   = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10,
    PH_DONE  = 2'b11
  } nvmpc_phase_t;

endpackage : nvmpc_pkg

// ---- hdl/nvmpc_regs.sv ----
// nvmpc_regs: register bank behind the serial link, plus the protection,
// latency and address checks used by the array access logic.
// assumes sck, cs and io come from the host and are oversampled by mclk.
`timescale 1ns/1ps
module nvmpc_regs
  import nvmpc_pkg::*;
(
  // clock, reset, factory load of the nonvolatile bytes
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        factory_init_in,
  // serial link pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        wp_n_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_data_out,
  output logic      [3:0]  io_oe_out,
  // array access side
  input  wire logic [21:0] acc_addr_in,
  input  wire logic        acc_aug_in,
  input  wire logic        acc_read_in,
  input  wire logic [1:0]  acc_rd_kind_in,
  input  wire logic        acc_wr_req_in,
  output logic             acc_protected_out,
  output logic             acc_wr_grant_out,
  output logic      [3:0]  acc_latency_out,
  output logic      [21:0] acc_next_addr_out,
  // interface mode
  output logic             quad_mode_flag_out,
  output logic             dual_mode_flag_out
);

  logic [2:0]   sck_p;
  logic [2:0]   cs_p;
  logic [3:0]   io_m;
  logic [3:0]   io_s;
  logic         wp_m;
  logic         wp_s;
  nvmpc_phase_t phase_r;
  nvmpc_phase_t phase_dec;
  logic [7:0]   rx_r;
  logic [7:0]   rx_nxt;
  logic [3:0]   cnt_r;
  logic [3:0]   cnt_nxt;
  logic [3:0]   step_c;
  logic [7:0]   cmd_r;
  logic [3:0]   idx_r;
  logic [7:0]   tx_r;
  logic [7:0]   tx_src;
  logic [7:0]   rd_byte;
  logic [2:0]   ocnt_r;
  logic         wr_ok_r;
  logic         wr_ok_nxt;
  logic         write_enable_latch_r;
  logic         reg_wr_seen_r;
  logic         arr_clr_r;
  logic [5:0]   status_nv_r;
  logic [7:0]   protection_lock_config_r;
  logic [7:0]   interface_latency_config_r;
  logic [7:0]   drive_wrap_config_r;
  logic [7:0]   write_enable_policy_config_r;
  logic [7:0]   aug_area_section_protect_r;
  logic [63:0]  user_serial_number_r;
  logic [31:0]  device_identification;
  logic [31:0]  cfg_all;
  logic [7:0]   status_c;
  logic [7:0]   ifc_c;
  logic [5:0]   bmask;
  logic         prot_c;
  logic         wel_ok;
  logic [21:0]  wmask;
  logic [21:0]  addr_inc;
  logic         sck_rise;
  logic         sck_fall;
  logic         cs_rise;
  logic         byte_done;
  logic         cmd_done;
  logic         wr_byte;
  logic         tx_load;
  logic         hw_prot;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only for edge detection
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sck_p <= 3'h0;
      cs_p  <= 3'h7;
      io_m  <= 4'h0;
      io_s  <= 4'h0;
      wp_m  <= 1'b1;
      wp_s  <= 1'b1;
    end else begin
      sck_p <= {sck_p[1:0], sck_in};
      cs_p  <= {cs_p[1:0], cs_n_in};
      io_m  <= io_in;
      io_s  <= io_m;
      wp_m  <= wp_n_in;
      wp_s  <= wp_m;
    end
  end

  assign sck_rise  = sck_p[1] & ~sck_p[2] & ~cs_p[1];
  assign sck_fall  = ~sck_p[1] & sck_p[2] & ~cs_p[1];
  assign cs_rise   = cs_p[1] & ~cs_p[2];
  assign hw_prot   = ~wp_s & status_nv_r[STAT_HPE_BIT - 2];
  assign step_c    = quad_mode_flag_out ? 4'h4 : (dual_mode_flag_out ? 4'h2 : 4'h1);
  assign cnt_nxt   = cnt_r + step_c;
  assign byte_done = sck_rise && (cnt_nxt == 4'h8);
  assign cmd_done  = byte_done && (phase_r == PH_CMD);
  assign wr_byte   = byte_done && (phase_r == PH_WRITE) && wr_ok_r;
  assign tx_load   = sck_fall && (phase_r == PH_READ) && (ocnt_r == 3'h0);

  always_comb begin
    if (quad_mode_flag_out) rx_nxt = {rx_r[3:0], io_s};
    else if (dual_mode_flag_out) rx_nxt = {rx_r[5:0], io_s[1:0]};
    else rx_nxt = {rx_r[6:0], io_s[0]};
  end

  always_comb begin
    case (rx_nxt)
      CMD_WR_STATUS, CMD_WR_CFGX, CMD_WR_SERIAL, CMD_WR_AUGPROT: phase_dec = PH_WRITE;
      CMD_RD_STATUS, CMD_RD_CFG1, CMD_RD_CFG2, CMD_RD_CFG3, CMD_RD_CFG4,
      CMD_RD_CFGX, CMD_RD_IDENT, CMD_RD_UNIQ, CMD_RD_SERIAL,
      CMD_RD_AUGPROT: phase_dec = PH_READ;
      default: phase_dec = PH_DONE;
    endcase
  end

  // register writes need the latch; hardware protection blocks all but the serial write, which the SNP bit blocks
  always_comb begin
    wr_ok_nxt = write_enable_latch_r;
    if (hw_prot && rx_nxt != CMD_WR_SERIAL) wr_ok_nxt = 1'b0;
    if (rx_nxt == CMD_WR_SERIAL && status_nv_r[STAT_SNP_BIT - 2]) wr_ok_nxt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing; chip select high restarts the frame
  always_ff @(posedge mclk_in) begin
    if (rst_in || cs_p[1]) begin
      phase_r <= PH_CMD;
      cnt_r   <= 4'h0;
      idx_r   <= 4'h0;
      rx_r    <= 8'h00;
      cmd_r   <= 8'h00;
      wr_ok_r <= 1'b0;
    end else begin
      if (sck_rise) begin
        rx_r  <= rx_nxt;
        cnt_r <= byte_done ? 4'h0 : cnt_nxt;
      end
      if (cmd_done) begin
        cmd_r   <= rx_nxt;
        phase_r <= phase_dec;
        wr_ok_r <= wr_ok_nxt;
      end else if (((byte_done && phase_r == PH_WRITE) || tx_load) && idx_r != 4'hF) begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interface mode flags, volatile
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      quad_mode_flag_out <= 1'b0;
      dual_mode_flag_out <= 1'b0;
    end else if (cmd_done) begin
      if (rx_nxt == CMD_QUAD_EN) begin
        quad_mode_flag_out <= 1'b1;
        dual_mode_flag_out <= 1'b0;
      end else if (rx_nxt == CMD_DUAL_EN) begin
        quad_mode_flag_out <= 1'b0;
        dual_mode_flag_out <= 1'b1;
      end else if (rx_nxt == CMD_SINGLE_EN) begin
        quad_mode_flag_out <= 1'b0;
        dual_mode_flag_out <= 1'b0;
      end
    end
  end

  // write-enable latch and the frame-end clear requests
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      write_enable_latch_r <= 1'b0;
      reg_wr_seen_r        <= 1'b0;
    end else begin
      if (cmd_done && rx_nxt == CMD_WR_ENABLE) write_enable_latch_r <= 1'b1;
      else if (cmd_done && rx_nxt == CMD_WR_DISABLE) write_enable_latch_r <= 1'b0;
      else if (cs_rise && (reg_wr_seen_r || arr_clr_r)) write_enable_latch_r <= 1'b0;
      if (cs_rise) reg_wr_seen_r <= 1'b0;
      else if (cmd_done && phase_dec == PH_WRITE) reg_wr_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nonvolatile bytes: untouched by rst_in, loaded only by factory init
  always_ff @(posedge mclk_in) begin
    if (factory_init_in) begin
      status_nv_r                  <= STAT_NV_DFLT;
      protection_lock_config_r     <= CFG_DFLT;
      interface_latency_config_r   <= CFG_DFLT;
      drive_wrap_config_r          <= CFG_DFLT;
      write_enable_policy_config_r <= CFG_DFLT;
      aug_area_section_protect_r   <= AUGP_DFLT;
      user_serial_number_r         <= SERIAL_DFLT;
    end else if (wr_byte) begin
      case (cmd_r)
        CMD_WR_STATUS: if (idx_r == 4'h0) begin
          status_nv_r[5:4] <= rx_nxt[7:6];
          if (!protection_lock_config_r[LOCK_ARRAY_BIT])
            status_nv_r[3:0] <= rx_nxt[5:2];
        end
        CMD_WR_CFGX: case (idx_r)
          4'h0: protection_lock_config_r <= rx_nxt;
          4'h1: interface_latency_config_r <= rx_nxt & ~IFC_FLAG_MASK;
          4'h2: drive_wrap_config_r <= rx_nxt;
          4'h3: write_enable_policy_config_r <= rx_nxt;
          default: ;
        endcase
        CMD_WR_SERIAL: if (idx_r < 4'h8)
          user_serial_number_r[{~idx_r[2:0], 3'b000} +: 8] <= rx_nxt;
        CMD_WR_AUGPROT: if (idx_r == 4'h0)
          aug_area_section_protect_r <= rx_nxt;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  assign status_c = {status_nv_r, write_enable_latch_r, 1'b0};
  assign ifc_c    = interface_latency_config_r & ~IFC_FLAG_MASK |
                    {1'b0, quad_mode_flag_out, 1'b0, dual_mode_flag_out, 4'h0};
  assign cfg_all  = {protection_lock_config_r, ifc_c, drive_wrap_config_r,
                     write_enable_policy_config_r};
  assign device_identification = {MAKER_CODE, IDENT_CONFIG};

  always_comb begin
    rd_byte = 8'h00;
    case (cmd_r)
      CMD_RD_STATUS:  if (idx_r == 4'h0) rd_byte = status_c;
      CMD_RD_CFG1:    if (idx_r == 4'h0) rd_byte = protection_lock_config_r;
      CMD_RD_CFG2:    if (idx_r == 4'h0) rd_byte = ifc_c;
      CMD_RD_CFG3:    if (idx_r == 4'h0) rd_byte = drive_wrap_config_r;
      CMD_RD_CFG4:    if (idx_r == 4'h0) rd_byte = write_enable_policy_config_r;
      CMD_RD_AUGPROT: if (idx_r == 4'h0) rd_byte = aug_area_section_protect_r;
      CMD_RD_CFGX:    if (idx_r < 4'h4) rd_byte = cfg_all[{~idx_r[1:0], 3'b000} +: 8];
      CMD_RD_IDENT:   if (idx_r < 4'h4)
        rd_byte = device_identification[{~idx_r[1:0], 3'b000} +: 8];
      CMD_RD_UNIQ:    if (idx_r < 4'h8) rd_byte = UNIQ_VALUE[{~idx_r[2:0], 3'b000} +: 8];
      CMD_RD_SERIAL:  if (idx_r < 4'h8)
        rd_byte = user_serial_number_r[{~idx_r[2:0], 3'b000} +: 8];
      default: rd_byte = 8'h00;
    endcase
  end

  assign tx_src = tx_load ? rd_byte : tx_r;

  // data leaves msb first on falling sck
  always_ff @(posedge mclk_in) begin
    if (rst_in || cs_p[1]) begin
      io_data_out <= 4'h0;
      io_oe_out   <= 4'h0;
      tx_r        <= 8'h00;
      ocnt_r      <= 3'h0;
    end else if (sck_fall && phase_r == PH_READ) begin
      ocnt_r <= ocnt_r + step_c[2:0];
      tx_r   <= tx_src << step_c;
      if (quad_mode_flag_out) begin
        io_data_out <= tx_src[7:4];
        io_oe_out   <= 4'hF;
      end else if (dual_mode_flag_out) begin
        io_data_out <= {2'b00, tx_src[7:6]};
        io_oe_out   <= 4'h3;
      end else begin
        io_data_out <= {2'b00, tx_src[7], 1'b0};
        io_oe_out   <= 4'h2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array access checks
  assign bmask    = 6'h3F << (status_nv_r[2:0] - 3'h1);
  assign wmask    = (WRAP_BASE << drive_wrap_config_r[2:0]) - 22'h000001;
  assign addr_inc = acc_addr_in + 22'h000001;
  assign wel_ok   = (write_enable_policy_config_r[1:0] == WEP_SRAM) || write_enable_latch_r;

  always_comb begin
    if (acc_aug_in)
      prot_c = protection_lock_config_r[LOCK_AUG_BIT] ||
               aug_area_section_protect_r[acc_addr_in[8:6]];
    else if (status_nv_r[2:0] == BPF_NONE) prot_c = 1'b0;
    else if (status_nv_r[2:0] == BPF_ALL) prot_c = 1'b1;
    else if (status_nv_r[STAT_TBS_BIT - 2]) prot_c = (acc_addr_in[21:16] & bmask) == 6'h00;
    else prot_c = (acc_addr_in[21:16] & bmask) == bmask;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_protected_out <= 1'b0;
      acc_wr_grant_out  <= 1'b0;
      acc_latency_out   <= LAT_NONE;
      acc_next_addr_out <= 22'h000000;
      arr_clr_r         <= 1'b0;
    end else begin
      acc_protected_out <= prot_c;
      acc_wr_grant_out  <= acc_wr_req_in && !prot_c && wel_ok;
      // a write request seen with the latch set arms the clear outside the SRAM and B2B policies, even one that protection refuses
      if (acc_wr_req_in && write_enable_latch_r &&
          write_enable_policy_config_r[1:0] != WEP_SRAM &&
          write_enable_policy_config_r[1:0] != WEP_B2B) arr_clr_r <= 1'b1;
      else if (cs_rise) arr_clr_r <= 1'b0;
      if (acc_rd_kind_in == RK_BASIC) acc_latency_out <= LAT_NONE;
      else if (acc_rd_kind_in != RK_ANYREG)
        acc_latency_out <= interface_latency_config_r[3:0];
      else if (quad_mode_flag_out) acc_latency_out <= LAT_ANY_4;
      else if (dual_mode_flag_out) acc_latency_out <= LAT_ANY_2;
      else acc_latency_out <= LAT_ANY_1;
      if (acc_read_in && drive_wrap_config_r[WRAP_EN_BIT] &&
          drive_wrap_config_r[2:0] != WRAP_RSVD)
        acc_next_addr_out <= (acc_addr_in & ~wmask) | (addr_inc & wmask);
      else acc_next_addr_out <= addr_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  quad_any_lat_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      acc_rd_kind_in == RK_ANYREG && quad_mode_flag_out |=> acc_latency_out == 4'h2)
    else $error("read-any latency in quad mode not 2");
  basic_lat_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      acc_rd_kind_in == RK_BASIC |=> acc_latency_out == 4'h0)
    else $error("basic read latency not zero");
  aug_lock_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      acc_aug_in && protection_lock_config_r[LOCK_AUG_BIT] |=> acc_protected_out)
    else $error("locked augmented area not protected");
  all_blocks_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !acc_aug_in && status_nv_r[2:0] == 3'h7 |=> acc_protected_out)
    else $error("full block protect missed");
  roll_over_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !acc_read_in && acc_addr_in == 22'h3FFFFF |=> acc_next_addr_out == 22'h000000)
    else $error("address did not roll to zero");
  sram_grant_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      acc_wr_req_in && !prot_c && write_enable_policy_config_r[1:0] == 2'h1
      |=> acc_wr_grant_out)
    else $error("sram policy write refused");
  reg_wel_clr_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      cs_rise && reg_wr_seen_r |=> !write_enable_latch_r)
    else $error("latch kept after register write");
  hw_block_a:
    assert property (@(posedge mclk_in) disable iff (rst_in || factory_init_in)
      phase_r == PH_WRITE && cmd_r == CMD_WR_STATUS && hw_prot |=> $stable(status_nv_r))
    else $error("status changed under hardware protect");
  single_mode_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
      cmd_done && rx_nxt == CMD_SINGLE_EN |=> !quad_mode_flag_out && !dual_mode_flag_out)
    else $error("mode flags not cleared");

endmodule : nvmpc_regs

// ---- test/nvmpc_host.sv ----
// nvmpc_host: single-line host model for the register link.
// assumes mclk_in is the bench clock; sck idles low outside frames.
`timescale 1ns/1ps
module nvmpc_host (
  // bench clock and answer lines
  input  wire logic       mclk_in,
  input  wire logic [3:0] io_data_in,
  // link pins
  output logic            sck_out,
  output logic            cs_n_out,
  output logic      [3:0] io_out
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    io_out   = 4'hA;
  end
  ////////////////////////////////////////////////////////////
  // bit copied to all lines so FF still reads as FF in dual/quad
  task automatic xfer(input logic [7:0] op, input int nw, input logic [63:0] w,
                      input int nr, output logic [63:0] r);
    logic [71:0] sh;
    sh = {op, w};
    r = 64'h0;
    @(negedge mclk_in);
    cs_n_out = 1'b0;
    repeat (4) @(negedge mclk_in);
    for (int i = 0; i < 8 * (1 + nw + nr); i++) begin
      sck_out = 1'b0;
      io_out  = {4{sh[71]}};
      sh      = sh << 1;
      repeat (4) @(negedge mclk_in);
      sck_out = 1'b1;
      if (i >= 8 * (1 + nw)) r = {r[62:0], io_data_in[1]};
      repeat (4) @(negedge mclk_in);
    end
    sck_out = 1'b0;
    repeat (4) @(negedge mclk_in);
    cs_n_out = 1'b1;
    io_out   = ~io_out;  // released lines never keep the last value
    repeat (4) @(negedge mclk_in);
  endtask : xfer
endmodule : nvmpc_host

// ---- test/nvmpc_regs_tb_top.sv ----
// nvmpc_regs_tb_top: self-checking bench for the register bank.
// assumes nvmpc_host drives the link; access side driven here.
`timescale 1ns/1ps
module nvmpc_regs_tb_top;
  import nvmpc_pkg::*;
  logic        mclk, rst, fin, sck, cs_n, wp_n, aug, rd, wrq, prot, gnt, qf, df;
  logic [3:0]  io, iod, ioe, lat;
  logic [1:0]  kind, md;
  logic [21:0] addr, nxt, x;
  logic [7:0]  st, c1, c2, c3, c4, aug_area_section_protect;
  logic [63:0] rv, sn;
  int          failures, total_checks;

  nvmpc_regs u_nvmpc_regs (.mclk_in(mclk), .rst_in(rst), .factory_init_in(fin),
    .sck_in(sck), .cs_n_in(cs_n), .wp_n_in(wp_n), .io_in(io), .io_data_out(iod),
    .io_oe_out(ioe), .acc_addr_in(addr), .acc_aug_in(aug), .acc_read_in(rd),
    .acc_rd_kind_in(kind), .acc_wr_req_in(wrq), .acc_protected_out(prot),
    .acc_wr_grant_out(gnt), .acc_latency_out(lat), .acc_next_addr_out(nxt),
    .quad_mode_flag_out(qf), .dual_mode_flag_out(df));
  nvmpc_host u_nvmpc_host (.mclk_in(mclk), .io_data_in(iod), .sck_out(sck),
    .cs_n_out(cs_n), .io_out(io));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic xf(input logic [7:0] op, input int nw = 0, input logic [63:0] w = '0,
                    input int nr = 0);
    u_nvmpc_host.xfer(op, nw, w, nr, rv);
  endtask : xf
  task automatic wr(input logic [7:0] op, input int nw, input logic [63:0] w);
    xf(CMD_WR_ENABLE);
    xf(op, nw, w);
  endtask : wr
  // one access cycle; outputs are settled at the returning edge
  task automatic ac(input logic [21:0] a, input logic au, input logic r,
                    input logic [1:0] k, input logic q);
    @(negedge mclk);
    {addr, aug, rd, kind, wrq} = {a, au, r, k, q};
    @(negedge mclk);
    wrq = 1'b0;
  endtask : ac
  function automatic logic ep(input logic [21:0] a, input logic au);
    logic [22:0] sz;
    sz = 23'h400000 >> (3'h7 - st[4:2]);
    if (au) return c1[0] | aug_area_section_protect[a[8:6]];
    if (st[4:2] == 3'h0 || st[4:2] == 3'h7) return st[2];
    return st[5] ? ({1'b0, a} < sz) : ({1'b0, a} >= 23'h400000 - sz);
  endfunction : ep
  function automatic logic [21:0] en(input logic [21:0] a, input logic r);
    logic [21:0] m;
    m = (22'h10 << c3[2:0]) - 22'h1;
    if (r && c3[4] && c3[2:0] != 3'h7) return (a & ~m) | ((a + 22'h1) & m);
    return a + 22'h1;
  endfunction : en
  function automatic logic [3:0] el(input logic [1:0] k);
    if (k == RK_BASIC) return LAT_NONE;
    if (k == RK_ANYREG) return md[1] ? LAT_ANY_4 : (md[0] ? LAT_ANY_2 : LAT_ANY_1);
    return c2[3:0];
  endfunction : el
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    end_of_test();
  end
  initial begin
    {rst, fin, wp_n} = 3'h5;
    {addr, aug, rd, kind, wrq, md} = 29'h0;
    void'($urandom(32'hC267));
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    fin = 1'b1;
    @(negedge mclk);
    fin = 1'b0;
    repeat (4) @(negedge mclk);
    xf(CMD_RD_CFGX, 0, '0, 4);
    chk(rv, 64'h0);
    xf(CMD_RD_AUGPROT, 0, '0, 1);
    chk(rv, 64'h0);
    xf(CMD_RD_IDENT, 0, '0, 4);
    chk(rv, {MAKER_CODE, IDENT_CONFIG});
    xf(CMD_RD_UNIQ, 0, '0, 8);
    chk(rv, UNIQ_VALUE);
    chk({qf, df, ioe}, 6'h0);
    xf(CMD_WR_STATUS, 1, {8'h1C, 56'h0});
    xf(CMD_RD_STATUS, 0, '0, 1);
    chk(rv, 64'h0);
    xf(CMD_WR_ENABLE);
    xf(CMD_RD_STATUS, 0, '0, 1);
    chk(rv, 64'h2);
    for (int t = 0; t < 16; t++) begin
      st = {2'h0, t[3:0], 2'h0};
      wr(CMD_WR_STATUS, 1, {st, 56'h0});
      xf(CMD_RD_STATUS, 0, '0, 1);
      chk(rv, st);
      for (int j = 0; j < 6; j++) begin
        x = (j > 3) ? 22'($urandom) : 22'((23'h400000 >> (3'h7 - st[4:2])) - 23'h1 + j[1]);
        ac(j[0] ? ~x : x, 1'b0, 1'b0, 2'h0, 1'b0);
        chk(prot, ep(addr, 1'b0));
      end
    end
    wr(CMD_WR_STATUS, 1, {8'h80, 56'h0});
    wp_n = 1'b0;
    wr(CMD_WR_STATUS, 1, {8'h9C, 56'h0});
    xf(CMD_RD_STATUS, 0, '0, 1);
    chk(rv, 64'h80);
    wp_n = 1'b1;
    st = 8'h00;
    wr(CMD_WR_STATUS, 1, {st, 56'h0});
    for (int p = 0; p < 16; p++) begin
      c1 = 8'($urandom) & 8'hFA | 8'h04 | {7'h0, p[0]};
      // latency 8 or more suits every read kind, augmented reads included
      c2 = {1'($urandom), 3'h5, 1'b1, 3'($urandom)};
      c3 = {3'($urandom), ~p[3], 1'($urandom), p[2:0]};
      c4 = {6'($urandom), 2'h0};
      wr(CMD_WR_CFGX, 4, {c1, c2, c3, c4, 32'h0});
      c2 = c2 & ~IFC_FLAG_MASK;
      xf(CMD_RD_CFGX, 0, '0, 4);
      chk(rv, {c1, c2, c3, c4});
      aug_area_section_protect = 8'($urandom);
      wr(CMD_WR_AUGPROT, 1, {aug_area_section_protect, 56'h0});
      for (int j = 0; j < 8; j++) begin
        ac({13'h0, j[2:0], 6'($urandom)}, 1'b1, j[0], j[2:1], 1'b0);
        chk(prot, ep(addr, 1'b1));
        chk(lat, el(kind));
        ac(j[0] ? 22'h3FFFFF : 22'($urandom), 1'b0, j[1], 2'h0, 1'b0);
        chk(nxt, en(addr, rd));
      end
    end
    wr(CMD_WR_STATUS, 1, {8'h1C, 56'h0});
    xf(CMD_RD_STATUS, 0, '0, 1);
    chk(rv, 64'h0);
    for (int m = 1; m < 3; m++) begin
      md = 2'(m);
      xf(m == 1 ? CMD_DUAL_EN : CMD_QUAD_EN);
      chk({qf, df}, md);
      ac(22'h0, 1'b0, 1'b1, RK_ANYREG, 1'b0);
      chk(lat, el(kind));
      xf(CMD_SINGLE_EN);
      md = 2'h0;
      chk({qf, df}, 2'h0);
    end
    sn = {$urandom, $urandom};
    wr(CMD_WR_SERIAL, 8, sn);
    xf(CMD_RD_SERIAL, 0, '0, 8);
    chk(rv, sn);
    // mid-run reset: latch and mode are volatile, the stored bytes are not
    xf(CMD_WR_ENABLE);
    xf(CMD_QUAD_EN);
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk({qf, df}, 2'h0);
    xf(CMD_RD_STATUS, 0, '0, 1);
    chk(rv, 64'h0);
    xf(CMD_RD_CFGX, 0, '0, 4);
    chk(rv, {c1, c2, c3, c4});
    xf(CMD_RD_AUGPROT, 0, '0, 1);
    chk(rv, aug_area_section_protect);
    for (int w = 0; w < 3; w++) begin
      c4 = {6'h0, 2'(w)};
      wr(CMD_WR_CFGX, 4, {c1, c2, c3, c4, 32'h0});
      ac(22'h0, 1'b0, 1'b0, 2'h0, 1'b1);
      chk(gnt, w == 1);
      xf(CMD_WR_ENABLE);
      ac(22'h0, 1'b0, 1'b0, 2'h0, 1'b1);
      chk(gnt, 1'b1);
      xf(CMD_RD_STATUS, 0, '0, 1);
      ac(22'h0, 1'b0, 1'b0, 2'h0, 1'b1);
      chk(gnt, w != 0);
      xf(CMD_WR_DISABLE);
      ac(22'h0, 1'b0, 1'b0, 2'h0, 1'b1);
      chk(gnt, w == 1);
    end
    end_of_test();
  end
endmodule : nvmpc_regs_tb_top
